//--- rtl/apdc_pkg.sv
// package with constants and carrier types for the auto power-down control
package apdc_pkg;

  // ****************************************************
  // idle counter
  // ****************************************************
  localparam int APDC_CNT_W = 4;
  localparam logic [3:0] APDC_IDLE_LIMIT = 4'hF;
  localparam logic [3:0] APDC_CNT_RST = 4'h0;

  // ****************************************************
  // logic standby settle time
  // ****************************************************
  localparam int APDC_CLK_NS = 40;
  localparam int APDC_SETTLE_NS = 70;
  localparam int APDC_SETTLE_CYC_RAW = APDC_SETTLE_NS / APDC_CLK_NS +
    ((APDC_SETTLE_NS % APDC_CLK_NS) != 0 ? 1 : 0);
  localparam int APDC_SETTLE_CYC = APDC_SETTLE_CYC_RAW < 1 ? 1 :
    APDC_SETTLE_CYC_RAW;
  localparam logic [3:0] APDC_SETTLE_CNT = 4'(APDC_SETTLE_CYC);

  // ****************************************************
  // register field positions
  // ****************************************************
  localparam int APDC_R0_FAST_OFF = 3;
  localparam int APDC_R0_CLK_AND = 4;
  localparam int APDC_R0_CLK_MCELL = 5;
  localparam int APDC_R2_ADDR_LO = 0;
  localparam int APDC_R2_CTL0 = 2;
  localparam int APDC_R2_CTL1 = 3;
  localparam int APDC_R2_CTL2 = 4;
  localparam int APDC_R2_STROBE = 5;
  localparam int APDC_R2_WEH = 6;
  localparam logic [7:0] APDC_REG_RST = 8'h00;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [0:0] {
    APDC_RUN = 1'b0,
    APDC_DOWN = 1'b1
  } apdc_state_t;

  typedef struct packed {
    logic [7:0] addr_lo;
    logic ctl0;
    logic ctl1;
    logic ctl2;
    logic strobe;
    logic weh;
    logic clk;
  } apdc_logic_in_t;

  typedef struct packed {
    logic flash_main_en;
    logic flash_sec_en;
    logic sram_en;
    logic io_en;
  } apdc_mem_en_t;

endpackage

//--- rtl/apdc_sync3.sv
// three flip-flop input synchroniser with agreement check
`timescale 1ns/1ps
module apdc_sync3
  import apdc_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a change counts once stages two and three agree
  assign q_next = (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= q_next;
    end
  end

endmodule

//--- rtl/apdc_top.sv
// automatic power-down control: idle counter, bus blocking, power bits
// Overview of operation
// RL1 - when enabled and strobe idles, a four-bit idle counter runs
// RL2 - fifteen idle clock periods raise the flag and enter power-down
// RL3 - enabling the unit enables power-down entry with no extra enable
// RL4 - strobe pulsing again returns the device to normal operation
// RL5 - chip select low or reset input low also leaves power-down
// RL6 - power-down blocks address and data bus from memories and logic arrays
// RL7 - blocking the clock from the logic still feeds the idle counter
// RL8 - power-down puts memories in standby; logic and I/O stay active
// RL9 - power-down tri-states data and peripheral I/O pins, address outputs undefined
// RL10 - power-down leaves logic behaviour alone; only fast-mode bit matters
// RL11 - control register zero bit 3 high means low power, low means fast
// RL12 - with fast mode off, logic idles after 70ns of stable inputs
// RL13 - chip select low enables memories and I/O; high disables memories
// RL14 - register zero bits 4 and 5 cut clock from array and macrocells
// RL15 - register two bits 0,2..6 cut address low byte and controls from array
// RL16 - counter stops when disabled or pulsing; counts at configured polarity
// RL17 - software should block clock and unused controls to save power
// RL18 - fast-mode bit resets to fast mode on
// RL19 - strobe activity clears the counter and the power-down flag together
`timescale 1ns/1ps
module apdc_top
  import apdc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic ADDRESS_STROBE_PIN,
  input wire logic IDLE_COUNT_CLOCK_PIN,
  input wire logic SELECT_PORT_PIN_B,
  input wire logic RESET_PIN_B,
  input wire logic APD_ENABLE,
  input wire logic STROBE_POLARITY,
  input wire logic [7:0] POWER_CTRL_REG_ZERO,
  input wire logic [7:0] POWER_CTRL_REG_TWO,
  input wire logic REG_WRITE,
  input wire logic [15:0] BUS_ADDR_IN,
  input wire logic [15:0] BUS_DATA_IN,
  input wire logic BUS_CTL0_IN,
  input wire logic BUS_CTL1_IN,
  input wire logic BUS_CTL2_IN,
  input wire logic BUS_WEH_IN,
  output logic POWER_DOWN_FLAG,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_DATA,
  output apdc_mem_en_t MEM_EN,
  output logic MEM_STANDBY,
  output logic [15:0] LOGIC_ADDR,
  output logic [15:0] LOGIC_DATA,
  output apdc_logic_in_t LOGIC_IN,
  output logic MCELL_CLK,
  output logic LOGIC_FAST,
  output logic LOGIC_STANDBY,
  output logic DATA_PORT_OE,
  output logic PERIPH_IO_OE,
  output logic ADDR_OUT_VALID,
  output logic [7:0] CTRL_ZERO_Q,
  output logic [7:0] CTRL_TWO_Q
);

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  logic strobe_s;
  logic cnt_clk_s;
  logic sel_b_s;
  logic rst_pin_b_s;
  logic weh_s;

  // active-low pins enter inverted so the reset state reads as inactive
  assign pins_raw = {BUS_WEH_IN, ~RESET_PIN_B, ~SELECT_PORT_PIN_B,
    IDLE_COUNT_CLOCK_PIN, ADDRESS_STROBE_PIN};

  apdc_sync3 #(
    .W(5)
  ) i_apdc_sync3 (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .d(pins_raw),
    .q(pins_s)
  );

  assign strobe_s = pins_s[0];
  assign cnt_clk_s = pins_s[1];
  assign sel_b_s = ~pins_s[2];
  assign rst_pin_b_s = ~pins_s[3];
  assign weh_s = pins_s[4];

  // ****************************************************
  // control registers
  // ****************************************************
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl0_next;
  logic [7:0] ctrl2_next;

  assign ctrl0_next = REG_WRITE ? POWER_CTRL_REG_ZERO : ctrl0_reg;
  assign ctrl2_next = REG_WRITE ? POWER_CTRL_REG_TWO : ctrl2_reg;

  // RL18 fast mode default
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl0_reg <= APDC_REG_RST;
      ctrl2_reg <= APDC_REG_RST;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // ****************************************************
  // edge detection on the synchronised pins
  // ****************************************************
  logic strobe_d_reg;
  logic cnt_clk_d_reg;
  logic strobe_edge;
  logic cnt_clk_rise;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      strobe_d_reg <= 1'b0;
      cnt_clk_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_s;
      cnt_clk_d_reg <= cnt_clk_s;
    end
  end

  assign strobe_edge = strobe_s ^ strobe_d_reg;
  assign cnt_clk_rise = cnt_clk_s & ~cnt_clk_d_reg;

  // ****************************************************
  // idle counter and power-down state
  // ****************************************************
  logic [3:0] idle_cnt_reg;
  logic [3:0] idle_cnt_next;
  apdc_state_t state_reg;
  apdc_state_t state_next;
  logic strobe_idle;
  logic wake;
  logic count_en;
  logic idle_done;

  // RL16 counts only at polarity level
  assign strobe_idle = APD_ENABLE & (strobe_s == STROBE_POLARITY);
  // RL7 counter sees the clock pin regardless of bits 4 and 5
  // RL1 count on idle clock periods
  assign count_en = strobe_idle & ~strobe_edge & cnt_clk_rise &
    (idle_cnt_reg != APDC_IDLE_LIMIT);
  // RL2 fifteen periods reached
  // RL3 no separate entry enable
  assign idle_done = strobe_idle & (idle_cnt_reg == APDC_IDLE_LIMIT);
  // RL4 strobe activity wakes
  // RL5 select low or reset pin low wakes
  assign wake = strobe_edge | ~sel_b_s | ~rst_pin_b_s | ~APD_ENABLE;

  // RL19 activity clears counter
  // RL16 stopped when disabled or pulsing
  assign idle_cnt_next = (strobe_edge | ~strobe_idle) ? APDC_CNT_RST :
    count_en ? idle_cnt_reg + 4'h1 : idle_cnt_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      APDC_RUN: begin
        if (idle_done && !wake) begin
          state_next = APDC_DOWN;
        end
      end
      APDC_DOWN: begin
        // RL19 flag clears on any wake; the counter clears with it only on strobe activity or disable
        if (wake) begin
          state_next = APDC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      idle_cnt_reg <= APDC_CNT_RST;
      state_reg <= APDC_RUN;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
      state_reg <= state_next;
    end
  end

  logic pd_next;
  assign pd_next = (state_next == APDC_DOWN);

  // ****************************************************
  // logic standby timer when fast mode is off
  // ****************************************************
  logic [3:0] settle_cnt_reg;
  logic [3:0] settle_cnt_next;
  logic logic_in_change;
  logic fast_off;
  apdc_logic_in_t logic_in_next;

  // RL11 bit 3 selects low power
  // RL10 only the fast-mode bit shapes logic power
  assign fast_off = ctrl0_reg[APDC_R0_FAST_OFF];

  // RL15 blocking bits for array inputs
  // RL6 power-down blocks the bus from the array too
  assign logic_in_next.addr_lo = (ctrl2_reg[APDC_R2_ADDR_LO] | pd_next) ?
    LOGIC_IN.addr_lo : BUS_ADDR_IN[7:0];
  assign logic_in_next.ctl0 = ctrl2_reg[APDC_R2_CTL0] ?
    LOGIC_IN.ctl0 : BUS_CTL0_IN;
  assign logic_in_next.ctl1 = ctrl2_reg[APDC_R2_CTL1] ?
    LOGIC_IN.ctl1 : BUS_CTL1_IN;
  assign logic_in_next.ctl2 = ctrl2_reg[APDC_R2_CTL2] ?
    LOGIC_IN.ctl2 : BUS_CTL2_IN;
  assign logic_in_next.strobe = ctrl2_reg[APDC_R2_STROBE] ?
    LOGIC_IN.strobe : strobe_s;
  assign logic_in_next.weh = ctrl2_reg[APDC_R2_WEH] ?
    LOGIC_IN.weh : weh_s;
  // RL14 clock cut from array and macrocells
  assign logic_in_next.clk = ctrl0_reg[APDC_R0_CLK_AND] ?
    1'b0 : cnt_clk_s;

  assign logic_in_change = (logic_in_next != LOGIC_IN);

  // RL12 standby after 70ns stable inputs
  assign settle_cnt_next = (logic_in_change | ~fast_off) ? APDC_CNT_RST :
    (settle_cnt_reg == APDC_SETTLE_CNT) ? settle_cnt_reg :
    settle_cnt_reg + 4'h1;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      settle_cnt_reg <= APDC_CNT_RST;
    end else begin
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // ****************************************************
  // memory and port gating
  // ****************************************************
  logic mem_sel;
  apdc_mem_en_t mem_en_next;

  // RL13 select gates memories, not I/O
  assign mem_sel = ~sel_b_s & ~pd_next;
  // RL8 memories standby, I/O stays active
  assign mem_en_next.flash_main_en = mem_sel;
  assign mem_en_next.flash_sec_en = mem_sel;
  assign mem_en_next.sram_en = mem_sel;
  assign mem_en_next.io_en = 1'b1;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      POWER_DOWN_FLAG <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_DATA <= 16'h0000;
      MEM_EN <= '0;
      MEM_STANDBY <= 1'b1;
      LOGIC_ADDR <= 16'h0000;
      LOGIC_DATA <= 16'h0000;
      LOGIC_IN <= '0;
      MCELL_CLK <= 1'b0;
      LOGIC_FAST <= 1'b1;
      LOGIC_STANDBY <= 1'b0;
      DATA_PORT_OE <= 1'b0;
      PERIPH_IO_OE <= 1'b0;
      ADDR_OUT_VALID <= 1'b0;
      CTRL_ZERO_Q <= APDC_REG_RST;
      CTRL_TWO_Q <= APDC_REG_RST;
    end else begin
      // RL2 flag follows power-down state
      POWER_DOWN_FLAG <= pd_next;
      // RL6 bus held off memories and arrays
      if (!pd_next) begin
        MEM_ADDR <= BUS_ADDR_IN;
        MEM_DATA <= BUS_DATA_IN;
        LOGIC_ADDR <= BUS_ADDR_IN;
        LOGIC_DATA <= BUS_DATA_IN;
      end
      MEM_EN <= mem_en_next;
      MEM_STANDBY <= ~mem_sel;
      LOGIC_IN <= logic_in_next;
      // RL14 macrocell clock gate
      MCELL_CLK <= ctrl0_reg[APDC_R0_CLK_MCELL] ? 1'b0 : cnt_clk_s;
      LOGIC_FAST <= ~fast_off;
      LOGIC_STANDBY <= fast_off & (settle_cnt_next == APDC_SETTLE_CNT);
      // RL9 data and peripheral ports tri-state, address out undefined
      DATA_PORT_OE <= ~pd_next & ~sel_b_s;
      PERIPH_IO_OE <= ~pd_next & ~sel_b_s;
      ADDR_OUT_VALID <= ~pd_next;
      CTRL_ZERO_Q <= ctrl0_next;
      CTRL_TWO_Q <= ctrl2_next;
    end
  end

endmodule

//--- bench/apdc_assertions.sv
// port checker for the auto power-down control
`timescale 1ns/1ps
module apdc_checker
  import apdc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic ADDRESS_STROBE_PIN,
  input wire logic SELECT_PORT_PIN_B,
  input wire logic APD_ENABLE,
  input wire logic [7:0] POWER_CTRL_REG_ZERO,
  input wire logic REG_WRITE,
  input wire logic POWER_DOWN_FLAG,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_DATA,
  input wire apdc_mem_en_t MEM_EN,
  input wire logic MEM_STANDBY,
  input wire logic [15:0] LOGIC_ADDR,
  input wire logic [15:0] LOGIC_DATA,
  input wire logic MCELL_CLK,
  input wire logic LOGIC_FAST,
  input wire logic DATA_PORT_OE,
  input wire logic PERIPH_IO_OE,
  input wire logic ADDR_OUT_VALID,
  input wire logic [7:0] CTRL_ZERO_Q
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ****************************************************
  // power-down effects
  // ****************************************************
  sequence pd_held;
    POWER_DOWN_FLAG && $past(POWER_DOWN_FLAG);
  endsequence
  pd_mem_off_a: assert property (pd_held |->
    !MEM_EN.flash_main_en && !MEM_EN.flash_sec_en && !MEM_EN.sram_en &&
    MEM_STANDBY)
    else $error("memories active in power-down");
  pd_pins_off_a: assert property (pd_held |->
    !DATA_PORT_OE && !PERIPH_IO_OE && !ADDR_OUT_VALID)
    else $error("port drivers active in power-down");
  pd_bus_hold_a: assert property (pd_held |->
    $stable(MEM_ADDR) && $stable(LOGIC_ADDR) &&
    $stable(MEM_DATA) && $stable(LOGIC_DATA))
    else $error("bus reached memories or logic in power-down");
  // ****************************************************
  // wake and counting
  // ****************************************************
  wake_strobe_a: assert property (POWER_DOWN_FLAG &&
    $changed(ADDRESS_STROBE_PIN) |-> ##[1:8] !POWER_DOWN_FLAG)
    else $error("strobe activity did not wake");
  wake_select_a: assert property (POWER_DOWN_FLAG &&
    !SELECT_PORT_PIN_B |-> ##[1:8] !POWER_DOWN_FLAG)
    else $error("chip select did not wake");
  apd_off_a: assert property (!APD_ENABLE [*8] |-> !POWER_DOWN_FLAG)
    else $error("power-down while unit disabled");
  desel_mem_a: assert property (SELECT_PORT_PIN_B [*8] |->
    !MEM_EN.flash_main_en && !MEM_EN.sram_en)
    else $error("memories enabled while deselected");
  // ****************************************************
  // power control bits
  // ****************************************************
  reg_load_a: assert property (REG_WRITE |=>
    CTRL_ZERO_Q == $past(POWER_CTRL_REG_ZERO))
    else $error("control register zero not loaded");
  fast_bit_a: assert property (LOGIC_FAST == !$past(CTRL_ZERO_Q[3]))
    else $error("fast mode does not follow bit 3");
  mcell_cut_a: assert property (CTRL_ZERO_Q[5] &&
    $past(CTRL_ZERO_Q[5]) |-> !MCELL_CLK)
    else $error("macrocell clock not cut");
  pd_entry_c: cover property ($rose(POWER_DOWN_FLAG));
  pd_exit_c: cover property ($fell(POWER_DOWN_FLAG));
  clk_cut_c: cover property (REG_WRITE && POWER_CTRL_REG_ZERO[5]);
endmodule

bind apdc_top apdc_checker i_apdc_checker (.*);

//--- bench/apdc_mcu_model.sv
// microcontroller bus model: address strobe, chip select, bus traffic
`timescale 1ns/1ps
module apdc_mcu_model (
  input wire logic clk,
  input wire logic pulse,
  input wire logic idle_level,
  input wire logic sel_b,
  output logic strobe,
  output logic select_b,
  output logic [15:0] addr,
  output logic [15:0] data
);
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    strobe = 1'b0;
    select_b = 1'b0;
    addr = 16'h0000;
    data = 16'h0000;
  end
  // bus keeps changing even when idle, like a noisy shared bus
  always @(posedge clk) begin
    #2;
    cnt <= cnt + 2'h1;
    if (!pulse)
      strobe <= idle_level;
    else if (cnt == 2'h3)
      strobe <= !strobe;
    select_b <= sel_b;
    addr <= 16'($urandom);
    data <= 16'($urandom);
  end
endmodule

//--- bench/apdc_top_test.sv
// self-checking bench for the auto power-down control
`timescale 1ns/1ps
module apdc_top_test;
  import apdc_pkg::*;
  logic clk, rst_b, strobe, icp, sel_b, sel_req, rpin_b, apd_en, pol, wr;
  logic pulse, c0, c1, c2, weh, pdf, stby, mclk, fast, lstby, doe, poe, aov;
  logic [7:0] r0, r2, q0, q2, v;
  logic [15:0] addr, data, ma, la, md, ld, hold;
  apdc_mem_en_t men;
  apdc_logic_in_t lin;
  int fail_count, tests_run, cyc;
  apdc_mcu_model i_apdc_mcu_model (.clk(clk), .pulse(pulse),
    .idle_level(pol), .sel_b(sel_req), .strobe(strobe), .select_b(sel_b),
    .addr(addr), .data(data));
  apdc_top i_apdc_top (.CLK_SYS(clk), .RST_B(rst_b),
    .ADDRESS_STROBE_PIN(strobe), .IDLE_COUNT_CLOCK_PIN(icp),
    .SELECT_PORT_PIN_B(sel_b), .RESET_PIN_B(rpin_b), .APD_ENABLE(apd_en),
    .STROBE_POLARITY(pol), .POWER_CTRL_REG_ZERO(r0),
    .POWER_CTRL_REG_TWO(r2), .REG_WRITE(wr), .BUS_ADDR_IN(addr),
    .BUS_DATA_IN(data), .BUS_CTL0_IN(c0), .BUS_CTL1_IN(c1),
    .BUS_CTL2_IN(c2), .BUS_WEH_IN(weh), .POWER_DOWN_FLAG(pdf),
    .MEM_ADDR(ma), .MEM_DATA(md), .MEM_EN(men), .MEM_STANDBY(stby),
    .LOGIC_ADDR(la), .LOGIC_DATA(ld), .LOGIC_IN(lin), .MCELL_CLK(mclk),
    .LOGIC_FAST(fast), .LOGIC_STANDBY(lstby), .DATA_PORT_OE(doe),
    .PERIPH_IO_OE(poe), .ADDR_OUT_VALID(aov), .CTRL_ZERO_Q(q0),
    .CTRL_TWO_Q(q2));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function logic exp_fast(logic [7:0] r);
    return !r[APDC_R0_FAST_OFF];
  endfunction
  task check(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task idle_rises(int n);
    repeat (n) begin
      icp = 1'b1;
      tick(4);
      icp = 1'b0;
      tick(4);
    end
  endtask
  task wrreg(logic [7:0] a, logic [7:0] b);
    r0 = a;
    r2 = b;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(3);
  endtask
  task results;
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    void'($urandom(42117));
    {rst_b, icp, apd_en, wr, sel_req, c0, c1, c2, weh} = 9'h000;
    {rpin_b, pol, pulse} = 3'h7;
    r0 = 8'h00;
    r2 = 8'h00;
    tick(4);
    rst_b = 1'b1;
    tick(6);
    check("fast", fast, 1'b1);
    repeat (6) begin
      v = 8'($urandom);
      {c0, c1, c2, weh} = 4'($urandom);
      wrreg(v, 8'($urandom));
      check("ctrl0", q0, r0);
      check("ctrl2", q2, r2);
      check("fast", fast, exp_fast(r0));
      if (r0[APDC_R0_CLK_MCELL])
        check("mclk", mclk, 1'b0);
      if (!r2[APDC_R2_CTL0])
        check("ctl0", lin.ctl0, c0);
      if (!r2[APDC_R2_CTL1])
        check("ctl1", lin.ctl1, c1);
      if (!r2[APDC_R2_CTL2])
        check("ctl2", lin.ctl2, c2);
    end
    wrreg(8'h00, 8'h01);
    hold = lin.addr_lo;
    tick(4);
    check("addr_lo", lin.addr_lo, hold[7:0]);
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 4; w++) begin
        // clock cut from logic while counting when p is 1, with all controls blocked
        wrreg(p ? 8'h30 : 8'h00, 8'h7D);
        pol = p[0];
        sel_req = 1'b1;
        apd_en = 1'b1;
        pulse = 1'b0;
        tick(8);
        idle_rises(14);
        check("flag14", pdf, 1'b0);
        idle_rises(1);
        tick(8);
        check("flag15", pdf, 1'b1);
        check("stby", stby, 1'b1);
        check("io_en", men.io_en, 1'b1);
        check("oe", {doe, poe, aov}, 3'b000);
        if (p)
          check("lclk", lin.clk, 1'b0);
        hold = ma;
        tick(3);
        check("mem_addr", ma, hold);
        hold = la;
        tick(3);
        check("logic_addr", la, hold);
        hold = md;
        v = {3'h0, lin.ctl0, lin.ctl1, lin.ctl2, lin.weh, lin.strobe};
        {c0, c1, c2, weh} = 4'($urandom);
        tick(8);
        check("mem_data", md, hold);
        check("ctl_block", {lin.ctl0, lin.ctl1, lin.ctl2}, v[4:2]);
        check("weh_block", {lin.weh, lin.strobe}, v[1:0]);
        hold = ld;
        tick(3);
        check("logic_data", ld, hold);
        case (w)
          0: pulse = 1'b1;
          1: sel_req = 1'b0;
          2: rpin_b = 1'b0;
          default: apd_en = 1'b0;
        endcase
        tick(12);
        check("wake", pdf, 1'b0);
        {pulse, rpin_b, sel_req, apd_en} = 4'hC;
        tick(8);
      end
    end
    sel_req = 1'b1;
    pulse = 1'b0;
    idle_rises(18);
    check("apd_off", pdf, 1'b0);
    check("desel", {men.flash_main_en, men.sram_en}, 2'b00);
    sel_req = 1'b0;
    pulse = 1'b1;
    tick(10);
    check("sel", {men.flash_main_en, men.sram_en}, 2'b11);
    wrreg(8'h38, 8'h7D);
    tick(4);
    check("lstby", lstby, 1'b1);
    wrreg(8'h00, 8'h7D);
    tick(4);
    check("lstby_fast", lstby, 1'b0);
    results();
  end
endmodule
